// ---- inc/ers_pkg.sv ----
// egress rule stage: shared constants, types and function list
// Function
// - exactly one table lookup per frame per destination port
// - table holds 256 programmable entries matched against the key
// - key bits 3:0 transmit port, bits 7:4 receive port, 0 to 11
// - key bit 10 set when destination address bit 40 is one
// - key bit 11 set only for the all-ones broadcast address
// - key bits 23:12 hold the classified vlan id
// - key bit 24 holds drop precedence after policing
// - key bits 27:25 hold the final classified priority
// - each lookup gives one action; a miss uses the port default
// - action bits 1:0 decode outer tag and port tag pushing
// - action bit 2 pushes the second tag as inner tag
// - action bits 4:3 select first tag identifier
// - action bit 5 selects first tag vlan id: sum or value
// - action bits 7:6 select first tag priority
// - action bits 9:8 select first tag drop-eligible bit
// - action bits 11:10 select second tag identifier likewise
// - action bit 12 selects second tag vlan id: sum or value
// - action bits 14:13 select second tag priority
// - action bits 16:15 select second tag drop-eligible bit
// - value fields at bits 17, 29, 32 and 33, 45, 48
// - sticky hit bit 73 set when the entry is the lowest-index match for a frame
package ers_pkg;
   localparam int ERS_KEY_W   = 28;
   localparam int ERS_ACT_W   = 74;
   localparam int ERS_ENTRIES = 256;
   localparam int ERS_PORTS   = 12;
   localparam int ERS_IDX_W   = 9;

   localparam int ERS_K_TXPORT = 0;
   localparam int ERS_K_RXPORT = 4;
   localparam int ERS_K_MC     = 10;
   localparam int ERS_K_BC     = 11;
   localparam int ERS_K_VID    = 12;
   localparam int ERS_K_DP     = 24;
   localparam int ERS_K_PCP    = 25;
   localparam int ERS_MAC_MC   = 40;

   localparam int ERS_A_OUTER  = 0;
   localparam int ERS_A_INNER  = 2;
   localparam int ERS_A_STICKY = 73;
   localparam int ERS_A_IDSEL  [2] = '{3, 10};
   localparam int ERS_A_VIDSEL [2] = '{5, 12};
   localparam int ERS_A_PRSEL  [2] = '{6, 13};
   localparam int ERS_A_DESEL  [2] = '{8, 15};
   localparam int ERS_A_VIDVAL [2] = '{17, 33};
   localparam int ERS_A_PRVAL  [2] = '{29, 45};
   localparam int ERS_A_DEVAL  [2] = '{32, 48};

   localparam logic [1:0] ERS_OUT_PORT_OPT = 2'h0;
   localparam logic [1:0] ERS_OUT_FIRST    = 2'h1;
   localparam logic [1:0] ERS_OUT_PORT_FRC = 2'h2;

   localparam logic [15:0] ERS_IDENT_CTAG = 16'h8100;
   localparam logic [15:0] ERS_IDENT_STAG = 16'h88A8;
   localparam logic [47:0] ERS_MAC_BCAST  = 48'hFFFFFFFFFFFF;

   localparam logic [7:0] ERS_REG_CMD    = 8'h00;
   localparam logic [7:0] ERS_REG_IDX    = 8'h04;
   localparam logic [7:0] ERS_REG_KDATA  = 8'h08;
   localparam logic [7:0] ERS_REG_KMASK  = 8'h0C;
   localparam logic [7:0] ERS_REG_ACT0   = 8'h10;
   localparam logic [7:0] ERS_REG_ACT1   = 8'h14;
   localparam logic [7:0] ERS_REG_ACT2   = 8'h18;
   localparam logic [7:0] ERS_REG_PIDENT = 8'h1C;
   localparam logic [7:0] ERS_REG_MAPLO  = 8'h20;
   localparam logic [7:0] ERS_REG_MAPHI  = 8'h24;
   localparam logic [7:0] ERS_REG_STATUS = 8'h28;

   localparam int ERS_CMD_ENT_WR  = 0;
   localparam int ERS_CMD_ENT_RD  = 1;
   localparam int ERS_CMD_PORT_WR = 2;
   localparam int ERS_CMD_PORT_RD = 3;
   localparam int ERS_KD_VALID    = 31;
   localparam int ERS_MAP_DE      = 3;

   localparam logic [ERS_ACT_W-1:0] ERS_ACT_RST   = 74'h0;
   localparam logic [15:0]          ERS_IDENT_RST = 16'h0000;
   localparam logic [63:0]          ERS_MAP_RST   = 64'h0;

   typedef struct packed {
      logic [3:0]  tx_port;
      logic [3:0]  rx_port;
      logic [47:0] dmac;
      logic [11:0] vid;
      logic        dp;
      logic [2:0]  pcp;
      logic        dei;
      logic [2:0]  qos;
      logic        tag_kind;
   } ers_req_t;

   typedef struct packed {
      logic [15:0] ident;
      logic [11:0] vid;
      logic [2:0]  prio;
      logic        dropelig;
   } ers_tag_t;

   typedef struct packed {
      logic [3:0] tx_port;
      logic       hit;
      logic       push_first;
      logic       port_tag_allow;
      logic       port_tag_force;
      logic       push_inner;
      ers_tag_t   tag_a;
      ers_tag_t   tag_b;
   } ers_res_t;
endpackage

// ---- src/ers_tag_sel.sv ----
// egress rule stage: field selection for one pushed tag
`timescale 1ns/1ps
module ers_tag_sel (
   // selectors from the action
   input  wire logic [1:0]       i_ident_sel,
   input  wire logic             i_vid_sel,
   input  wire logic [1:0]       i_prio_sel,
   input  wire logic [1:0]       i_de_sel,
   // configured values from the action
   input  wire logic [11:0]      i_vid_val,
   input  wire logic [2:0]       i_prio_val,
   input  wire logic             i_de_val,
   // frame and port context
   input  wire ers_pkg::ers_req_t i_frame,
   input  wire logic [15:0]      i_custom_ident,
   input  wire logic [3:0]       i_map_nib,
   // resulting tag fields
   output ers_pkg::ers_tag_t     o_tag
);
   wire [15:0] kind_ident = i_frame.tag_kind ? i_custom_ident
                                             : ers_pkg::ERS_IDENT_CTAG;
   wire [11:0] vid_sum = 12'(i_frame.vid + i_vid_val);

   assign o_tag.ident = (i_ident_sel == 2'h0) ? ers_pkg::ERS_IDENT_CTAG :
                        (i_ident_sel == 2'h1) ? ers_pkg::ERS_IDENT_STAG :
                        (i_ident_sel == 2'h2) ? i_custom_ident :
                                                kind_ident;
   assign o_tag.vid = i_vid_sel ? i_vid_val : vid_sum;
   assign o_tag.prio = (i_prio_sel == 2'h0) ? i_frame.pcp :
                       (i_prio_sel == 2'h1) ? i_prio_val :
                       (i_prio_sel == 2'h2) ? i_map_nib[2:0] :
                                              i_frame.qos;
   assign o_tag.dropelig =
      (i_de_sel == 2'h0) ? i_frame.dei :
      (i_de_sel == 2'h1) ? i_de_val :
      (i_de_sel == 2'h2) ? i_map_nib[ers_pkg::ERS_MAP_DE] :
                           i_frame.dp;
endmodule

// ---- src/ers_egress_rule_stage.sv ----
// egress rule stage: key build, rule table match and action decode
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ers_egress_rule_stage (
   // clock, reset, enable
   input  wire logic              i_mclk,
   input  wire logic              i_arst_n,
   input  wire logic              i_clk_en,
   // lookup request per frame and destination port
   input  wire logic              i_req_valid,
   input  wire ers_pkg::ers_req_t i_req,
   // lookup result to the rewriter
   output logic                   o_res_valid,
   output ers_pkg::ers_res_t      o_res,
   // apb slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [7:0]        i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic                   o_pready,
   output logic [31:0]            o_prdata,
   output logic                   o_pslverr
);
   localparam int KW = ers_pkg::ERS_KEY_W;
   localparam int AW = ers_pkg::ERS_ACT_W;
   localparam int NE = ers_pkg::ERS_ENTRIES;
   localparam int NP = ers_pkg::ERS_PORTS;

   // out-of-range port numbers fold onto port 0 instead of indexing off
   function automatic logic [3:0] port_sel(input logic [3:0] p);
      return (p < 4'(NP)) ? p : 4'h0;
   endfunction

   // table storage
   logic [KW-1:0]        key_mem  [NE];
   logic [KW-1:0]        mask_mem [NE];
   logic [AW-1:0]        ent_act  [NE];
   logic [NE-1:0]        ent_vld_reg;
   logic [AW-1:0]        def_act  [NP];
   logic [15:0]          pident   [NP];
   logic [63:0]          pmap     [NP];

   // software staging registers
   logic [8:0]           idx_reg;
   logic [31:0]          kd_reg;
   logic [KW-1:0]        km_reg;
   logic [AW-1:0]        act_reg;
   logic [15:0]          pid_reg;
   logic [63:0]          pmap_reg;
   logic                 last_hit_reg;
   logic [7:0]           last_idx_reg;

   // pipeline
   logic                 s1_vld_reg;
   logic [KW-1:0]        s1_key_reg;
   ers_pkg::ers_req_t    s1_req_reg;
   logic                 s2_vld_reg;
   logic                 s2_hit_reg;
   logic [AW-1:0]        s2_act_reg;
   ers_pkg::ers_req_t    s2_req_reg;
   logic [KW-1:0]        req_key;
   logic                 hit_any;
   logic [7:0]           hit_idx;
   logic [NE-1:0]        ent_match;
   ers_pkg::ers_tag_t    tag_res [2];
   ers_pkg::ers_res_t    res_next;
   logic [31:0]          rdata_next;
   logic                 err_next;

   // key assembly
   always_comb begin
      req_key = '0;
      req_key[ers_pkg::ERS_K_TXPORT +: 4] = i_req.tx_port;
      req_key[ers_pkg::ERS_K_RXPORT +: 4] = i_req.rx_port;
      req_key[ers_pkg::ERS_K_MC] = i_req.dmac[ers_pkg::ERS_MAC_MC];
      req_key[ers_pkg::ERS_K_BC] = (i_req.dmac == ers_pkg::ERS_MAC_BCAST);
      req_key[ers_pkg::ERS_K_VID +: 12] = i_req.vid;
      req_key[ers_pkg::ERS_K_DP] = i_req.dp;
      req_key[ers_pkg::ERS_K_PCP +: 3] = i_req.pcp;
   end

   // parallel compare; mask bit 1 means the key bit must match
   genvar g;
   generate
      for (g = 0; g < NE; g++) begin : g_match
         assign ent_match[g] = ent_vld_reg[g] &&
            (((s1_key_reg ^ key_mem[g]) & mask_mem[g]) == '0);
      end
   endgenerate

   // lowest index wins when several entries match
   always_comb begin
      hit_any = 1'b0;
      hit_idx = 8'h00;
      for (int i = NE - 1; i >= 0; i--) begin
         if (ent_match[i]) begin
            hit_any = 1'b1;
            hit_idx = 8'(i);
         end
      end
   end

   wire [3:0]    s1_port  = port_sel(s1_req_reg.tx_port);
   wire [AW-1:0] dflt_act = def_act[s1_port];
   wire [AW-1:0] sel_act  = hit_any ? ent_act[hit_idx] : dflt_act;

   // apb decode
   wire apb_setup = i_psel && !i_penable;
   wire apb_wr    = i_psel && i_penable && o_pready && i_pwrite;
   wire wr_cmd    = apb_wr && (i_paddr == ers_pkg::ERS_REG_CMD);
   wire ent_wr    = wr_cmd && i_pwdata[ers_pkg::ERS_CMD_ENT_WR];
   wire ent_rd    = wr_cmd && i_pwdata[ers_pkg::ERS_CMD_ENT_RD];
   wire port_wr   = wr_cmd && i_pwdata[ers_pkg::ERS_CMD_PORT_WR];
   wire port_rd   = wr_cmd && i_pwdata[ers_pkg::ERS_CMD_PORT_RD];
   wire idx_ent   = !idx_reg[8];
   wire idx_def   = idx_reg[8] && (idx_reg[7:0] < 8'(NP));
   wire [7:0] ei  = idx_reg[7:0];
   wire [3:0] pi  = port_sel(idx_reg[3:0]);

   always_comb begin
      rdata_next = 32'h0;
      err_next   = 1'b0;
      unique case (i_paddr)
         ers_pkg::ERS_REG_CMD:    rdata_next = 32'h0;
         ers_pkg::ERS_REG_IDX:    rdata_next = {23'h0, idx_reg};
         ers_pkg::ERS_REG_KDATA:  rdata_next = kd_reg;
         ers_pkg::ERS_REG_KMASK:  rdata_next = {4'h0, km_reg};
         ers_pkg::ERS_REG_ACT0:   rdata_next = act_reg[31:0];
         ers_pkg::ERS_REG_ACT1:   rdata_next = act_reg[63:32];
         ers_pkg::ERS_REG_ACT2:   rdata_next = {22'h0, act_reg[73:64]};
         ers_pkg::ERS_REG_PIDENT: rdata_next = {16'h0, pid_reg};
         ers_pkg::ERS_REG_MAPLO:  rdata_next = pmap_reg[31:0];
         ers_pkg::ERS_REG_MAPHI:  rdata_next = pmap_reg[63:32];
         ers_pkg::ERS_REG_STATUS:
            rdata_next = {23'h0, last_hit_reg, last_idx_reg};
         default:                 err_next   = 1'b1;
      endcase
   end
   // zero wait states: pready rises for the access phase
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0;
         o_pslverr <= 1'b0;
      end else if (i_clk_en) begin
         o_pready  <= apb_setup;
         o_pslverr <= apb_setup && err_next;
         if (apb_setup) begin
            o_prdata <= rdata_next;
         end
      end
   end
   // staging registers; a read command copies the table word back
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         idx_reg  <= 9'h000;
         kd_reg   <= 32'h0;
         km_reg   <= 28'h0;
         act_reg  <= ers_pkg::ERS_ACT_RST;
         pid_reg  <= ers_pkg::ERS_IDENT_RST;
         pmap_reg <= ers_pkg::ERS_MAP_RST;
      end else if (i_clk_en) begin
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_IDX)
            idx_reg <= i_pwdata[8:0];
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_KDATA)
            kd_reg <= i_pwdata;
         else if (ent_rd && idx_ent)
            kd_reg <= {ent_vld_reg[ei], 3'h0, key_mem[ei]};
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_KMASK)
            km_reg <= i_pwdata[KW-1:0];
         else if (ent_rd && idx_ent)
            km_reg <= mask_mem[ei];
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_ACT0)
            act_reg[31:0] <= i_pwdata;
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_ACT1)
            act_reg[63:32] <= i_pwdata;
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_ACT2)
            act_reg[73:64] <= i_pwdata[9:0];
         if (ent_rd && idx_ent)
            act_reg <= ent_act[ei];
         else if (ent_rd && idx_def)
            act_reg <= def_act[ei[3:0]];
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_PIDENT)
            pid_reg <= i_pwdata[15:0];
         else if (port_rd)
            pid_reg <= pident[pi];
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_MAPLO)
            pmap_reg[31:0] <= i_pwdata;
         else if (port_rd)
            pmap_reg[31:0] <= pmap[pi][31:0];
         if (apb_wr && i_paddr == ers_pkg::ERS_REG_MAPHI)
            pmap_reg[63:32] <= i_pwdata;
         else if (port_rd)
            pmap_reg[63:32] <= pmap[pi][63:32];
      end
   end
   // table data; entries are unusable until their valid bit is set
   always_ff @(posedge i_mclk) begin
      if (i_clk_en) begin
         if (ent_wr && idx_ent) begin
            key_mem[ei]  <= kd_reg[KW-1:0];
            mask_mem[ei] <= km_reg;
            ent_act[ei]  <= act_reg;
         end
         // sticky set after the write so a hit is never lost
         if (s1_vld_reg && hit_any)
            ent_act[hit_idx][ers_pkg::ERS_A_STICKY] <= 1'b1;
      end
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ent_vld_reg <= '0;
         for (int p = 0; p < NP; p++) begin
            def_act[p] <= ers_pkg::ERS_ACT_RST;
            pident[p]  <= ers_pkg::ERS_IDENT_RST;
            pmap[p]    <= ers_pkg::ERS_MAP_RST;
         end
      end else if (i_clk_en) begin
         if (ent_wr && idx_ent)
            ent_vld_reg[ei] <= kd_reg[ers_pkg::ERS_KD_VALID];
         if (ent_wr && idx_def)
            def_act[ei[3:0]] <= act_reg;
         if (port_wr) begin
            pident[pi] <= pid_reg;
            pmap[pi]   <= pmap_reg;
         end
      end
   end
   // one pass per request: key, match, decode
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_vld_reg   <= 1'b0;
         s1_key_reg   <= '0;
         s1_req_reg   <= '0;
         s2_vld_reg   <= 1'b0;
         s2_hit_reg   <= 1'b0;
         s2_act_reg   <= ers_pkg::ERS_ACT_RST;
         s2_req_reg   <= '0;
         last_hit_reg <= 1'b0;
         last_idx_reg <= 8'h00;
      end else if (i_clk_en) begin
         s1_vld_reg <= i_req_valid;
         s2_vld_reg <= s1_vld_reg;
         if (i_req_valid) begin
            s1_key_reg <= req_key;
            s1_req_reg <= i_req;
         end
         if (s1_vld_reg) begin
            s2_hit_reg   <= hit_any;
            s2_act_reg   <= sel_act;
            s2_req_reg   <= s1_req_reg;
            last_hit_reg <= hit_any;
            last_idx_reg <= hit_idx;
         end
      end
   end
   // per-port dp/qos map nibble, indexed by {dp, qos}
   wire [3:0]  s2_port = port_sel(s2_req_reg.tx_port);
   wire [5:0]  nib_pos = {s2_req_reg.dp, s2_req_reg.qos, 2'h0};
   wire [3:0]  map_nib = pmap[s2_port][nib_pos +: 4];
   wire [15:0] cust_id = pident[s2_port];
   generate
      for (g = 0; g < 2; g++) begin : g_tag
         ers_tag_sel u_tag (
            .i_ident_sel    (s2_act_reg[ers_pkg::ERS_A_IDSEL[g] +: 2]),
            .i_vid_sel      (s2_act_reg[ers_pkg::ERS_A_VIDSEL[g]]),
            .i_prio_sel     (s2_act_reg[ers_pkg::ERS_A_PRSEL[g] +: 2]),
            .i_de_sel       (s2_act_reg[ers_pkg::ERS_A_DESEL[g] +: 2]),
            .i_vid_val      (s2_act_reg[ers_pkg::ERS_A_VIDVAL[g] +: 12]),
            .i_prio_val     (s2_act_reg[ers_pkg::ERS_A_PRVAL[g] +: 3]),
            .i_de_val       (s2_act_reg[ers_pkg::ERS_A_DEVAL[g]]),
            .i_frame        (s2_req_reg),
            .i_custom_ident (cust_id),
            .i_map_nib      (map_nib),
            .o_tag          (tag_res[g])
         );
      end
   endgenerate
   wire [1:0] outer = s2_act_reg[ers_pkg::ERS_A_OUTER +: 2];
   always_comb begin
      res_next         = '0;
      res_next.tx_port = s2_req_reg.tx_port;
      res_next.hit     = s2_hit_reg;
      // outer tag decode; code 3 pushes neither
      res_next.push_first     = (outer == ers_pkg::ERS_OUT_FIRST);
      res_next.port_tag_allow = (outer == ers_pkg::ERS_OUT_PORT_OPT);
      res_next.port_tag_force = (outer == ers_pkg::ERS_OUT_PORT_FRC);
      res_next.push_inner = s2_act_reg[ers_pkg::ERS_A_INNER];
      res_next.tag_a      = tag_res[0];
      res_next.tag_b      = tag_res[1];
   end
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_res_valid <= 1'b0;
         o_res       <= '0;
      end else if (i_clk_en) begin
         o_res_valid <= s2_vld_reg;
         if (s2_vld_reg)
            o_res <= res_next;
      end
   end
   wire [11:0] vid_sum_a = 12'(s2_req_reg.vid + s2_act_reg[28:17]);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   chk_key_ports: assert property (
      (i_clk_en && i_req_valid) |=>
         s1_key_reg[3:0] == $past(i_req.tx_port) &&
         s1_key_reg[7:4] == $past(i_req.rx_port))
      else $error("key port fields wrong");
   chk_key_mcast: assert property (
      (i_clk_en && i_req_valid) |=>
         s1_key_reg[10] == $past(i_req.dmac[40]))
      else $error("multicast key bit wrong");
   chk_key_bcast: assert property (
      (i_clk_en && i_req_valid) |=>
         s1_key_reg[11] == ($past(i_req.dmac) == 48'hFFFFFFFFFFFF))
      else $error("broadcast key bit wrong");
   chk_key_vlan: assert property (
      (i_clk_en && i_req_valid) |=>
         s1_key_reg[23:12] == $past(i_req.vid) &&
         s1_key_reg[24] == $past(i_req.dp) &&
         s1_key_reg[27:25] == $past(i_req.pcp))
      else $error("vlan key fields wrong");
   chk_one_result: assert property (
      (i_clk_en && i_req_valid) ##1 i_clk_en ##1 i_clk_en |=>
         o_res_valid)
      else $error("request did not give a result");
   chk_miss_default: assert property (
      (i_clk_en && s1_vld_reg && !hit_any) |=>
         s2_act_reg == $past(dflt_act) && !s2_hit_reg)
      else $error("miss did not use port default");
   chk_sticky_set: assert property (
      (i_clk_en && s1_vld_reg && hit_any) |=>
         ent_act[$past(hit_idx)][73])
      else $error("sticky hit bit not set");
   chk_outer_first: assert property (
      (i_clk_en && s2_vld_reg && s2_act_reg[1:0] == 2'h1) |=>
         o_res.push_first && !o_res.port_tag_allow &&
         !o_res.port_tag_force)
      else $error("outer tag decode wrong");
   chk_inner_push: assert property (
      (i_clk_en && s2_vld_reg) |=>
         o_res_valid && o_res.push_inner == $past(s2_act_reg[2]))
      else $error("inner tag push wrong");
   chk_ident_ctag: assert property (
      (i_clk_en && s2_vld_reg && s2_act_reg[4:3] == 2'h0) |=>
         o_res.tag_a.ident == 16'h8100)
      else $error("first tag identifier wrong");
   chk_vid_wrap: assert property (
      (i_clk_en && s2_vld_reg && !s2_act_reg[5]) |=>
         o_res.tag_a.vid == $past(vid_sum_a))
      else $error("first tag vid sum wrong");
   chk_apb_ready: assert property (
      (i_clk_en && i_psel && !i_penable) |=> o_pready)
      else $error("pready missing in access phase");
endmodule

// ---- sim/ers_frame_peer.sv ----
// frame peer: issues lookups and collects results for the rewriter
`timescale 1ns/1ps
module ers_frame_peer (
   // clock
   input  wire logic              i_mclk,
   // request side
   output logic                   o_req_valid,
   output ers_pkg::ers_req_t      o_req,
   // result side
   input  wire logic              i_res_valid,
   input  wire ers_pkg::ers_res_t i_res
);
   initial begin
      o_req_valid = 1'b0;
      o_req = '0;
   end
   // one pulse per frame per port
   task automatic lookup(input ers_pkg::ers_req_t r,
                         output ers_pkg::ers_res_t res);
      int n;
      @(posedge i_mclk);
      o_req_valid <= 1'b1;
      o_req <= r;
      @(posedge i_mclk);
      o_req_valid <= 1'b0;
      // released fields carry garbage, not the last frame
      o_req <= ~r;
      res = 'x;
      for (n = 0; n < 20; n++) begin
         @(posedge i_mclk);
         if (i_res_valid === 1'b1) begin
            res = i_res;
            break;
         end
      end
   endtask
endmodule

// ---- sim/ers_egress_rule_stage_tb.sv ----
// bench for the egress rule stage: apb programming and lookups
`timescale 1ns/1ps
module ers_egress_rule_stage_tb;
   logic              i_mclk = 1'b0;
   logic              i_arst_n = 1'b0;
   logic              psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, prdata, rd;
   logic              pready, pslverr, err, rv, qv;
   logic [73:0]       a;
   ers_pkg::ers_req_t q;
   ers_pkg::ers_res_t res, e, got;
   int                err_total = 0, total_checks = 0;
   logic [2:0]        pr [4] = '{3'h6, 3'h0, 3'h5, 3'h4};
   logic [15:0]       id [4] = '{16'h8100, 16'h88A8, 16'h9200, 16'h9200};
   always #5 i_mclk = ~i_mclk;
   ers_egress_rule_stage uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
      .i_clk_en(1'b1), .i_req_valid(qv), .i_req(q), .o_res_valid(rv),
      .o_res(res), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr));
   ers_frame_peer peer (.i_mclk(i_mclk), .o_req_valid(qv), .o_req(q),
      .i_res_valid(rv), .i_res(res));
   task chk(input string nm, input logic [127:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge i_mclk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge i_mclk);
      pen <= 1'b1;
      // only the watchdog ends a wait for pready
      do @(posedge i_mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   // table word at idx from key data, key mask and action a
   task ent(input logic [8:0] ix, input logic [31:0] kd, km);
      wr(ers_pkg::ERS_REG_IDX, {23'h0, ix});
      wr(ers_pkg::ERS_REG_KDATA, kd);
      wr(ers_pkg::ERS_REG_KMASK, km);
      wr(ers_pkg::ERS_REG_ACT0, a[31:0]);
      wr(ers_pkg::ERS_REG_ACT1, a[63:32]);
      wr(ers_pkg::ERS_REG_ACT2, {22'h0, a[73:64]});
      wr(ers_pkg::ERS_REG_CMD, 32'h1);
   endtask
   task port(input logic [3:0] p, input logic [15:0] ci);
      wr(ers_pkg::ERS_REG_IDX, {28'h0, p});
      wr(ers_pkg::ERS_REG_PIDENT, {16'h0, ci});
      // map nibble for dp 1, qos 4: prio 5, drop-eligible 1
      wr(ers_pkg::ERS_REG_MAPHI, 32'h000D0000);
      wr(ers_pkg::ERS_REG_CMD, 32'h4);
   endtask
   function automatic ers_pkg::ers_req_t mk(logic [3:0] t, logic [47:0] m,
                                            logic [11:0] v);
      mk = '{tx_port: t, rx_port: 4'h1, dmac: m, vid: v, dp: 1'b1,
             pcp: 3'h6, dei: 1'b1, qos: 3'h4, tag_kind: 1'b1};
   endfunction
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      close_out();
   end
   initial begin
      logic [47:0] mac [4];
      mac = '{48'h010000000000, 48'h0, 48'hFFFFFFFFFFFF, 48'h010000000000};
      repeat (8) @(posedge i_mclk);
      chk("reset valid", rv, 1'b0);
      i_arst_n <= 1'b1;
      port(4'h3, 16'h9200);
      port(4'h5, 16'h9100);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         a = 74'(c) | (74'(c) << 3) | (74'(c) << 6) | (74'(c) << 8);
         ent(9'd259, 32'h0, 32'h0);
         peer.lookup(mk(4'h3, 48'h2, 12'h345), e);
         got = e;
         e = '0;
         e.tx_port = 4'h3;
         e.port_tag_allow = (c == 0);
         e.push_first = (c == 1);
         e.port_tag_force = (c == 2);
         e.tag_a = '{id[c], 12'h345, pr[c], c != 1};
         e.tag_b = '{16'h8100, 12'h345, 3'h6, 1'b1};
         chk("default action", got, e);
      end
      $display("test default done");
      a = 74'h1F94D | (74'h2 << 17) | (74'h5 << 29) | (74'h1 << 32)
          | (74'h123 << 33);
      ent(9'd0, 32'h80FFF005, 32'h00FFF00F);
      peer.lookup(mk(4'h5, 48'h2, 12'hFFF), e);
      got = e;
      e = '{4'h5, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1,
            '{16'h88A8, 12'h001, 3'h5, 1'b1},
            '{16'h9100, 12'h123, 3'h4, 1'b1}};
      chk("hit action", got, e);
      wr(ers_pkg::ERS_REG_IDX, 32'h0);
      wr(ers_pkg::ERS_REG_CMD, 32'h2);
      apb(1'b0, ers_pkg::ERS_REG_ACT2, 32'h0);
      chk("sticky", rd[9], 1'b1);
      $display("test hit done");
      a = 74'h3;
      ent(9'd1, 32'h80000407, 32'h0000040F);
      ent(9'd2, 32'h80000808, 32'h0000080F);
      for (int k = 0; k < 4; k++) begin
         peer.lookup(mk(k < 2 ? 4'h7 : 4'h8, mac[k], 12'h010), e);
         chk("addr class hit", e.hit, k == 0 || k == 2);
      end
      $display("test class done");
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("test apb done");
      close_out();
   end
endmodule
